// ---- rtl/bmp_port.sv ----
// boot mode capture, status pin, reset input and serial channel of the programming port
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "bmp_cfg.svh"
module bmp_port #(
  parameter logic [15:0] BAUD_DIV = `BMP_BAUD_DIV_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic startup_mode_pin_0,
  input wire logic startup_mode_pin_1,
  input wire logic reset_in_n,
  input wire logic opcode_fetch_first,
  input wire logic int_ack,
  output logic status_pin,
  output logic cpu_reset_n,
  output logic program_mode,
  output logic [15:0] start_addr,
  output logic cold_boot,
  output logic debug_enable,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic txd,
  input wire logic rxd
);
  import bmp_pkg::*;

  // pin synchronisers: first stage feeds only the second
  logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
  always_comb begin
    sync1_d = {startup_mode_pin_1, startup_mode_pin_0, reset_in_n, rxd};
    sync2_d = sync1_q;
  end
  always_ff @(posedge aclk) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
  end
  // link clock: two flip-flops, then a third for edge finding; left unreset so the
  // delayed copy always tracks the pin and no false edge follows reset
  logic [1:0] sc_sync_q, sc_sync_d;
  logic sc_prev_q, sc_prev_d;
  always_comb begin
    sc_sync_d = {sc_sync_q[0], sclk_in};
    sc_prev_d = sc_sync_q[1];
  end
  always_ff @(posedge aclk) begin
    sc_sync_q <= sc_sync_d;
    sc_prev_q <= sc_prev_d;
  end
  logic sclk_rise, sclk_fall;
  assign sclk_rise = sc_sync_q[1] && !sc_prev_q;
  assign sclk_fall = !sc_sync_q[1] && sc_prev_q;

  // reset held while either reset source asserted
  logic rst_q, rst_d;
  logic started_q, started_d;
  logic [1:0] mode_q, mode_d;
  always_comb begin
    rst_d = !aresetn || !sync2_q[1];
    started_d = started_q;
    mode_d = mode_q;
    if (rst_q) begin
      started_d = 1'b0;
    end else if (!started_q) begin
      // capture once at release; pin changes later are ignored
      started_d = 1'b1;
      mode_d = sync2_q[3:2];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_q <= 1'b1;
      started_q <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      rst_q <= rst_d;
      started_q <= started_d;
      mode_q <= mode_d;
    end
  end
  // mixed pin levels fall back to run mode, the safe choice
  always_comb begin
    cpu_reset_n = !rst_q && started_q;
    program_mode = started_q && (mode_q == BMP_BOOT_PROGRAM_CONNECTOR);
    cold_boot = program_mode;
    start_addr = `BMP_RUN_ADDR;
    debug_enable = program_mode;
  end

  // register file
  logic [1:0] stat_sel_q, stat_sel_d;
  logic gpo_q, gpo_d, sync_mode_q, sync_mode_d, clone_q, clone_d;
  logic [7:0] tx_byte_q, tx_byte_d, rx_byte_q, rx_byte_d;
  logic tx_go_q, tx_go_d, rx_full_q, rx_full_d;
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [`BMP_ADDR_W-1:0] awa_q, awa_d, ara_idx;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic busy;
  logic rx_done;
  logic [7:0] rx_word;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  // addresses above the register window decode as a hole, so they answer with an error
  assign ara_idx = (|araddr[31:`BMP_ADDR_W]) ? `BMP_OFF_HOLE : araddr[`BMP_ADDR_W-1:0];
  always_comb begin
    awready = !aw_q && !b_q;
    wready = !w_q && !b_q;
    arready = !r_q;
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    b_d = b_q;
    bresp_d = bresp_q;
    stat_sel_d = stat_sel_q;
    gpo_d = gpo_q;
    sync_mode_d = sync_mode_q;
    clone_d = clone_q;
    tx_byte_d = tx_byte_q;
    tx_go_d = 1'b0;
    rx_byte_d = rx_byte_q;
    rx_full_d = rx_full_q;
    r_d = r_q;
    rd_d = rd_q;
    rresp_d = rresp_q;
    if (awvalid && awready) begin
      aw_d = 1'b1;
      awa_d = (|awaddr[31:`BMP_ADDR_W]) ? `BMP_OFF_HOLE : awaddr[`BMP_ADDR_W-1:0];
    end
    if (wvalid && wready) begin
      w_d = 1'b1;
      wd_d = wdata;
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = `BMP_RESP_OKAY;
      case (awa_q)
        `BMP_OFF_CTRL: begin
          stat_sel_d = wd_q[1:0];
          gpo_d = wd_q[2];
          sync_mode_d = wd_q[3];
          clone_d = wd_q[4];
        end
        `BMP_OFF_TXD: begin
          if (!busy) begin
            tx_byte_d = wd_q[7:0];
            tx_go_d = 1'b1;
          end
        end
        `BMP_OFF_STAT, `BMP_OFF_RXD: bresp_d = `BMP_RESP_OKAY;
        default: bresp_d = `BMP_RESP_SLVERR;
      endcase
    end
    if (b_q && bready) begin
      b_d = 1'b0;
    end
    if (rx_done) begin
      rx_byte_d = rx_word;
      rx_full_d = 1'b1; // set wins over the read clear below
    end
    if (arvalid && arready) begin
      r_d = 1'b1;
      rresp_d = `BMP_RESP_OKAY;
      case (ara_idx)
        `BMP_OFF_CTRL: rd_d = {27'h0, clone_q, sync_mode_q, gpo_q, stat_sel_q};
        `BMP_OFF_STAT: rd_d = {26'h0, rx_full_q, busy, mode_q, program_mode, started_q};
        `BMP_OFF_TXD: rd_d = {24'h0, tx_byte_q};
        `BMP_OFF_RXD: begin
          rd_d = {24'h0, rx_byte_q};
          if (!rx_done) begin
            rx_full_d = 1'b0;
          end
        end
        default: begin
          rd_d = 32'h0;
          rresp_d = `BMP_RESP_SLVERR;
        end
      endcase
    end else if (r_q && rready) begin
      r_d = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awa_q <= '0;
      wd_q <= 32'h0;
      rd_q <= 32'h0;
      bresp_q <= `BMP_RESP_OKAY;
      rresp_q <= `BMP_RESP_OKAY;
      stat_sel_q <= BMP_STAT_FETCH;
      gpo_q <= 1'b1;
      sync_mode_q <= 1'b0;
      clone_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_go_q <= 1'b0;
      rx_byte_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      stat_sel_q <= stat_sel_d;
      gpo_q <= gpo_d;
      sync_mode_q <= sync_mode_d;
      clone_q <= clone_d;
      tx_byte_q <= tx_byte_d;
      tx_go_q <= tx_go_d;
      rx_byte_q <= rx_byte_d;
      rx_full_q <= rx_full_d;
    end
  end
  assign bvalid = b_q;
  assign bresp = bresp_q;
  assign rvalid = r_q;
  assign rdata = rd_q;
  assign rresp = rresp_q;

  // status pin: low the cycle after the selected cycle; high while in reset so host sees presence
  logic status_q, status_d;
  always_comb begin
    case (stat_sel_q)
      BMP_STAT_FETCH: status_d = !opcode_fetch_first;
      BMP_STAT_IACK: status_d = !int_ack;
      BMP_STAT_GPO: status_d = gpo_q;
      default: status_d = 1'b1;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 1'b1;
    end else begin
      status_q <= status_d;
    end
  end
  assign status_pin = status_q;

  // serial channel: sync mode uses the local divided clock out when ctrl bit 4 is set, else the host's link clock; async uses baud ticks
  bmp_ser_st_t st_q, st_d;
  logic [15:0] div_q, div_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, rsh_q, rsh_d;
  logic sck_q, sck_d, txd_q, txd_d, done_q, done_d;
  logic tick, ext_clk;
  // serial link usable in both program mode and run mode; nothing here gates it on program_mode
  assign tick = (div_q == 16'h0);
  // clocked mode with the clock pin released: the host supplies the link clock
  assign ext_clk = sync_mode_q && !clone_q;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rsh_d = rsh_q;
    sck_d = sck_q;
    txd_d = txd_q;
    done_d = 1'b0;
    div_d = tick ? BAUD_DIV : div_q - 16'h1;
    case (st_q)
      BMP_S_IDLE: begin
        txd_d = 1'b1;
        if (tx_go_q) begin
          sh_d = tx_byte_q;
          cnt_d = sync_mode_q ? `BMP_BIT_COUNT : `BMP_AFRAME_BITS;
          txd_d = sync_mode_q ? tx_byte_q[0] : 1'b0; // start bit in async
          st_d = BMP_S_SHIFT;
          div_d = BAUD_DIV;
        end else if (ext_clk && sclk_rise) begin
          // first bit arrives on the host's first rising edge
          rsh_d = {sync2_q[0], rsh_q[7:1]};
          cnt_d = `BMP_BIT_COUNT - 4'h1;
          st_d = BMP_S_SHIFT;
        end
      end
      BMP_S_SHIFT: begin
        if (ext_clk) begin
          // host clock: sample on its rising edge, next tx bit on its falling edge
          if (sclk_rise) begin
            rsh_d = {sync2_q[0], rsh_q[7:1]};
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
              st_d = BMP_S_DONE;
            end
          end else if (sclk_fall) begin
            sh_d = {1'b1, sh_q[7:1]};
            txd_d = sh_q[1];
          end
        end else if (tick) begin
          if (sync_mode_q) begin
            sck_d = !sck_q;
            if (!sck_q) begin
              rsh_d = {sync2_q[0], rsh_q[7:1]};
              cnt_d = cnt_q - 4'h1;
            end else begin
              sh_d = {1'b1, sh_q[7:1]};
              txd_d = sh_q[1];
              if (cnt_q == 4'h0) begin
                st_d = BMP_S_DONE;
              end
            end
          end else begin
            txd_d = (cnt_q == 4'h1) ? 1'b1 : sh_q[0];
            sh_d = {1'b1, sh_q[7:1]};
            rsh_d = {sync2_q[0], rsh_q[7:1]};
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
              st_d = BMP_S_DONE;
            end
          end
        end
      end
      BMP_S_DONE: begin
        txd_d = 1'b1;
        sck_d = 1'b0;
        done_d = 1'b1;
        st_d = BMP_S_IDLE;
      end
      default: st_d = BMP_S_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= BMP_S_IDLE;
      div_q <= 16'h0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rsh_q <= 8'h00;
      sck_q <= 1'b0;
      txd_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rsh_q <= rsh_d;
      sck_q <= sck_d;
      txd_q <= txd_d;
      done_q <= done_d;
    end
  end
  assign busy = (st_q != BMP_S_IDLE);
  assign rx_done = done_q;
  assign rx_word = rsh_q;
  assign txd = txd_q;
  // pin driven only while ctrl bit 4 is set; in async mode it carries the gpo bit
  assign sclk_out = sync_mode_q ? sck_q : gpo_q;
  assign sclk_oe = clone_q;

  // a_mode_held and friends
  a_mode_held: assert property (@(posedge aclk) disable iff (!aresetn)
    started_q && $past(started_q) |-> mode_q == $past(mode_q))
    else $error("boot mode changed during operation");
  a_program_connector_select: assert property (@(posedge aclk) disable iff (!aresetn)
    program_mode |-> mode_q == 2'h3 && debug_enable)
    else $error("program mode without both pins high");
  a_run_start: assert property (@(posedge aclk) disable iff (!aresetn)
    started_q && mode_q == 2'h0 |-> !program_mode && start_addr == 16'h0000)
    else $error("run mode start wrong");
  a_dbg_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    debug_enable |-> program_mode)
    else $error("debug allowed outside program mode");
  a_status_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_sel_q == 2'h0 && opcode_fetch_first ##1 stat_sel_q == 2'h0 |-> !status_pin)
    else $error("status not low on fetch");
  a_status_iack: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_sel_q == 2'h1 && int_ack ##1 stat_sel_q == 2'h1 |-> !status_pin)
    else $error("status not low on iack");
  a_status_gpo: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_sel_q == 2'h2 ##1 stat_sel_q == 2'h2 |-> status_pin == $past(gpo_q))
    else $error("status not following gpo");
  a_reset_in: assert property (@(posedge aclk) disable iff (!aresetn)
    !sync2_q[1] |-> ##1 !cpu_reset_n ##1 !cpu_reset_n)
    else $error("reset input ignored");
  a_async_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_go_q && !sync_mode_q |=> !txd)
    else $error("no start bit");
  c_program_connector_boot: cover property (@(posedge aclk) $rose(program_mode));
  c_run_boot: cover property (@(posedge aclk) $rose(started_q) ##1 !program_mode);
  c_rx_byte: cover property (@(posedge aclk) rx_done);
  c_iack_low: cover property (@(posedge aclk) stat_sel_q == 2'h1 && !status_pin);
endmodule : bmp_port

// ---- shared/bmp_cfg.svh ----
// constants for the boot mode / programming port block
`ifndef BMP_CFG_SVH
`define BMP_CFG_SVH
`define BMP_ADDR_W 4
`define BMP_OFF_CTRL 4'h0
`define BMP_OFF_STAT 4'h4
`define BMP_OFF_TXD 4'h8
`define BMP_OFF_RXD 4'hc
`define BMP_OFF_HOLE 4'h1
`define BMP_RUN_ADDR 16'h0000
`define BMP_RESP_OKAY 2'b00
`define BMP_RESP_SLVERR 2'b10
`define BMP_CTRL_RST 32'h0000_0000
`define BMP_BAUD_DIV_DEF 16'h0010
`define BMP_BIT_COUNT 4'h8
`define BMP_AFRAME_BITS 4'h9
`endif

// ---- shared/bmp_pkg.sv ----
// types for the boot mode / programming port block
package bmp_pkg;
  typedef enum logic [1:0] {
    BMP_STAT_FETCH = 2'h0,
    BMP_STAT_IACK = 2'h1,
    BMP_STAT_GPO = 2'h2
  } bmp_stat_sel_t;
  typedef enum logic [1:0] {
    BMP_BOOT_RUN = 2'h0,
    BMP_BOOT_PROGRAM_CONNECTOR = 2'h3
  } bmp_boot_t;
  typedef enum logic [2:0] {
    BMP_S_IDLE = 3'b001,
    BMP_S_SHIFT = 3'b010,
    BMP_S_DONE = 3'b100
  } bmp_ser_st_t;
endpackage : bmp_pkg

// ---- tb/bmp_host.sv ----
// host side model: cable strap pins, presence probe and clocked byte sender
`timescale 1ns/10ps
module bmp_host (
  input wire logic attached,
  input wire logic status_pin,
  output logic startup_mode_pin_0,
  output logic startup_mode_pin_1,
  output logic sclk_in,
  output logic rxd
);
  // cable pulls both strap pins high, board pulls them low without it
  assign startup_mode_pin_0 = attached;
  assign startup_mode_pin_1 = attached;
  // idle line high so no false start is seen before setup
  initial begin
    sclk_in = 1'b0;
    rxd = 1'b1;
  end
  // processor counts as present while its status output idles high
  function automatic logic present();
    return attached && (status_pin === 1'b1);
  endfunction : present
  // one clocked byte, lsb first; link clock runs only inside the frame
  task automatic send_sync(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #40 sclk_in = 1'b1;
      #40 sclk_in = 1'b0;
    end
    rxd = ~b[7]; // no pull-up on the receive line, so show a changed level
  endtask : send_sync
endmodule : bmp_host

// ---- tb/bmp_port_bench.sv ----
// self-checking bench for the programming port block
`timescale 1ns/10ps
`include "bmp_cfg.svh"
module bmp_port_bench;
  import bmp_pkg::*;
  localparam int T = 8; // bit time with the divider below
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, opcode_fetch_first, int_ack, status_pin, cpu_reset_n, program_mode;
  logic cold_boot, debug_enable, sclk_in, sclk_out, sclk_oe, txd, rxd, attached, reset_in_n;
  logic startup_mode_pin_0, startup_mode_pin_1;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] start_addr;
  logic [7:0] b;
  logic [7:0] q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int n, sel;
  logic f, k, g;

  always #4 aclk = ~aclk;
  bmp_port #(.BAUD_DIV(16'h0007)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .startup_mode_pin_0(startup_mode_pin_0), .startup_mode_pin_1(startup_mode_pin_1),
    .reset_in_n(reset_in_n), .opcode_fetch_first(opcode_fetch_first), .int_ack(int_ack),
    .status_pin(status_pin), .cpu_reset_n(cpu_reset_n), .program_mode(program_mode),
    .start_addr(start_addr), .cold_boot(cold_boot), .debug_enable(debug_enable),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .txd(txd), .rxd(rxd)
  );
  bmp_host host (
    .attached(attached), .status_pin(status_pin),
    .startup_mode_pin_0(startup_mode_pin_0), .startup_mode_pin_1(startup_mode_pin_1),
    .sclk_in(sclk_in), .rxd(rxd)
  );

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask : chk

  // write; readies sampled mid-cycle where they are settled; only the watchdog ends a wait
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (b_ok !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr

  // read, same pattern
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar_ok, r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_ok = arvalid & arready;
      r_ok = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end while (r_ok !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // watchdog well past the expected run length
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  // main sequence
  initial begin
    void'($urandom(6159));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, opcode_fetch_first, int_ack} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    reset_in_n = 1'b1;
    attached = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(program_mode, 0, "run mode");
    chk({cold_boot, debug_enable}, 0, "no boot or debug in run");
    chk(start_addr, `BMP_RUN_ADDR, "start address");
    attached <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(program_mode, 0, "mode held after capture");
    chk(host.present(), 1, "presence");
    $display("test run_mode done");
    // port reset input re-enters reset and recaptures the straps
    reset_in_n <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(cpu_reset_n, 0, "port reset");
    @(posedge aclk);
    reset_in_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({program_mode, cold_boot, debug_enable, cpu_reset_n}, 4'hf, "program mode");
    axi_rd(`BMP_OFF_STAT, d, r);
    chk(d & 32'he, 32'he, "captured straps");
    axi_rd(32'h10, d, r);
    chk({r, d}, {`BMP_RESP_SLVERR, 32'h0}, "unmapped read");
    axi_wr(32'h14, 32'h1, r);
    chk(r, `BMP_RESP_SLVERR, "unmapped write");
    $display("test program_mode done");
    // every status function with random core strobes
    for (int i = 0; i < 9; i++) begin
      sel = i % 3;
      {f, k, g} = 3'($urandom);
      axi_wr(`BMP_OFF_CTRL, {29'h0, g, 2'(sel)}, r);
      opcode_fetch_first <= f;
      int_ack <= k;
      repeat (3) @(posedge aclk);
      chk(status_pin, sel == 0 ? !f : sel == 1 ? !k : g, "status");
    end
    opcode_fetch_first <= 1'b0;
    int_ack <= 1'b0;
    $display("test status done");
    // async frame: start, eight bits lsb first, stop
    b = 8'($urandom);
    axi_wr(`BMP_OFF_TXD, {24'h0, b}, r);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (txd !== 1'b0 && n < 100);
    repeat (2) @(negedge aclk);
    for (int i = 0; i < 9; i++) begin
      repeat (T) @(negedge aclk);
      chk(txd, i < 8 ? b[i] : 1'b1, "tx bit");
    end
    repeat (T) @(posedge aclk);
    $display("test async_tx done");
    // clocked receive with the host supplying the link clock
    axi_wr(`BMP_OFF_CTRL, 32'h8, r);
    chk(sclk_oe, 0, "clock pin released");
    b = 8'($urandom);
    q.push_back(b);
    host.send_sync(b);
    @(posedge aclk);
    n = 0;
    do begin
      axi_rd(`BMP_OFF_STAT, d, r);
      n++;
    end while (d[5] !== 1'b1 && n < 50);
    chk(d[5], 1, "rx full");
    axi_rd(`BMP_OFF_RXD, d, r);
    chk(d[7:0], q.pop_front(), "sync rx byte");
    // clocked transmit with the block driving the clock pin
    axi_wr(`BMP_OFF_CTRL, 32'h18, r);
    chk(sclk_oe, 1, "clock pin driven");
    axi_wr(`BMP_OFF_TXD, 32'h5a, r);
    n = 0;
    f = sclk_out;
    repeat (100) begin
      @(negedge aclk);
      if (sclk_out !== f) n++;
      f = sclk_out;
    end
    chk(n != 0, 1, "clock toggles");
    $display("test sync done");
    final_report();
  end
endmodule : bmp_port_bench
